// file: hdl/tpwm_pkg.sv
package tpwm_pkg;
  // Register byte addresses on the Avalon-MM slave
  localparam logic [5:0] TPWM_OFS_CTL0 = 6'h00;
  localparam logic [5:0] TPWM_OFS_CTL1 = 6'h04;
  localparam logic [5:0] TPWM_OFS_OUTPIN = 6'h08;
  localparam logic [5:0] TPWM_OFS_INEDGE = 6'h0C;
  localparam logic [5:0] TPWM_OFS_CNT = 6'h10;
  localparam logic [5:0] TPWM_OFS_CCR0 = 6'h14;
  localparam logic [5:0] TPWM_OFS_CCR1 = 6'h18;
  localparam logic [5:0] TPWM_OFS_CCR2 = 6'h1C;
  localparam logic [5:0] TPWM_OFS_CCR3 = 6'h20;
  // timer_control_0 fields
  localparam int TPWM_RUN_BIT = 7;
  localparam int TPWM_CKS_LSB = 0;
  // timer_control_1 fields
  localparam int TPWM_EST_BIT = 6;
  localparam int TPWM_EEE_BIT = 5;
  localparam int TPWM_MD_LSB = 0;
  localparam logic [2:0] TPWM_MODE_TRIG_PWM = 3'h2;
  // input_edge_control fields: event edge high pair, trigger low pair
  localparam int TPWM_EES_LSB = 2;
  localparam int TPWM_ETS_LSB = 0;
  // Edge select codes
  localparam logic [1:0] TPWM_EDGE_NONE = 2'h0;
  localparam logic [1:0] TPWM_EDGE_RISE = 2'h1;
  localparam logic [1:0] TPWM_EDGE_FALL = 2'h2;
  // Reset values
  localparam logic [7:0] TPWM_RST_BYTE = 8'h00;
  localparam logic [15:0] TPWM_RST_CCR = 16'h0000;
  localparam logic [15:0] TPWM_CNT_IDLE = 16'hFFFF;
  // Prescaler divider width
  localparam int TPWM_DIV_W = 7;
  // Counter states
  typedef enum logic [1:0] {TPWM_IDLE, TPWM_WAIT, TPWM_RUN} tpwm_state_t;
endpackage

// file: hdl/tpwm_edge_if.sv
`timescale 1ns/1ns
`default_nettype none
interface tpwm_edge_if;
  // Edge select code and detected valid-edge pulse
  logic [1:0] sel;
  logic pulse;
  modport det(input sel, output pulse);
  modport core(output sel, input pulse);
endinterface
`default_nettype wire

// file: hdl/tpwm_edge_det.sv
`timescale 1ns/1ns
`default_nettype none
module tpwm_edge_det
  import tpwm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  tpwm_edge_if.det eif
);
  // Two-stage synchroniser, then one stage of history
  logic sync1_r;
  logic sync2_r;
  logic prev_r;

  // Pin synchroniser and edge history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Valid edge according to the select code
  always_comb begin
    if (eif.sel == TPWM_EDGE_NONE) begin
      eif.pulse = 1'b0;
    end else if (eif.sel == TPWM_EDGE_RISE) begin
      eif.pulse = sync2_r & ~prev_r;
    end else if (eif.sel == TPWM_EDGE_FALL) begin
      eif.pulse = ~sync2_r & prev_r;
    end else begin
      eif.pulse = sync2_r ^ prev_r;
    end
  end
endmodule
`default_nettype wire

// file: hdl/tpwm_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module tpwm_prescaler
  import tpwm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] cks,
  output logic tick
);
  // Free-running divider
  logic [TPWM_DIV_W-1:0] div_r;
  logic [TPWM_DIV_W-1:0] mask;

  // Divider count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // One tick every two to the power cks clocks
  always_comb begin
    mask = TPWM_DIV_W'((8'h01 << cks) - 8'h01);
    tick = (div_r & mask) == mask;
  end
endmodule
`default_nettype wire

// file: hdl/tpwm_timer.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Mode code 010 selects triggered PWM
// - Enabled timer waits, trigger clears, counts
// - Retrigger while counting restarts from zero
// - Trigger inverts toggle, forces phases high
// - Period is cycle value plus one
// - Phase active width equals phase compare
// - Toggle half period cycle plus one
// - Cycle irq and clear step after match
// - Phase irq on counter equal compare
// - Shadows load at enable and at armed cycle clear
// - Trigger is pin edge or soft bit
// - Event select picks prescaler or event edges
// - Disabled pin drives its level bit
// - Edge selects for trigger and event inputs
// - Counter readback returns present count
// - Phase below cycle: one irq per cycle
// - Phase above cycle: never an irq
// - Capture pins and option register ignored
// - Phase one write arms buffer transfer
module tpwm_timer
  import tpwm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic trigger_input,
  input wire logic event_count_input,
  output logic cycle_toggle_output,
  output logic [2:0] pwm_phase_output,
  output logic cycle_match_irq,
  output logic [2:0] phase_match_irq
);
  import tpwm_pkg::*;

  // Software registers
  logic [7:0] ctl0_r;
  logic [7:0] ctl1_r;
  logic [7:0] outpin_r;
  logic [7:0] inedge_r;
  logic [15:0] ccr_r [4];
  // Compare shadows used by the counter
  logic [15:0] shadow_r [4];
  logic armed_r;
  // Bus handshake
  logic ack_r;
  logic [31:0] rdata_r;
  logic wr_hit;
  // Counter core
  tpwm_state_t state_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_inc;
  logic [15:0] cnt_step;
  logic tog_r;
  logic [2:0] wave_r;
  logic [3:0] wave_src; // Internal level per pin, toggle in bit 0
  logic [3:0] pins_r;
  logic cyc_irq_r;
  logic [2:0] ph_irq_r;
  logic soft_trig_r;
  // Decoded conditions
  logic active;
  logic pre_tick;
  logic tick;
  logic trig;
  logic at_cycle;
  logic wrap;
  logic load;

  tpwm_edge_if trig_if();
  tpwm_edge_if evt_if();

  // Merge a write into a 16-bit register by byte enables
  function automatic logic [15:0] upd16(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] be);
    upd16 = old;
    if (be[0]) begin
      upd16[7:0] = d[7:0];
    end
    if (be[1]) begin
      upd16[15:8] = d[15:8];
    end
  endfunction

  // Read multiplexer; unmapped addresses read zero
  function automatic logic [31:0] rd_mux(input logic [5:0] a);
    rd_mux = 32'h0000_0000;
    if (a == TPWM_OFS_CTL0) begin
      rd_mux[7:0] = ctl0_r;
    end else if (a == TPWM_OFS_CTL1) begin
      rd_mux[7:0] = ctl1_r;
    end else if (a == TPWM_OFS_OUTPIN) begin
      rd_mux[7:0] = outpin_r;
    end else if (a == TPWM_OFS_INEDGE) begin
      rd_mux[7:0] = inedge_r;
    end else if (a == TPWM_OFS_CNT) begin
      rd_mux[15:0] = cnt_r;
    end else if (a == TPWM_OFS_CCR0) begin
      rd_mux[15:0] = ccr_r[0];
    end else if (a == TPWM_OFS_CCR1) begin
      rd_mux[15:0] = ccr_r[1];
    end else if (a == TPWM_OFS_CCR2) begin
      rd_mux[15:0] = ccr_r[2];
    end else if (a == TPWM_OFS_CCR3) begin
      rd_mux[15:0] = ccr_r[3];
    end
  endfunction

  // Trigger and event pin edge detectors
  tpwm_edge_det u_trig_det (
    .clk(clk),
    .reset(reset),
    .pin(trigger_input),
    .eif(trig_if.det)
  );

  tpwm_edge_det u_evt_det (
    .clk(clk),
    .reset(reset),
    .pin(event_count_input),
    .eif(evt_if.det)
  );

  // Internal count clock enable
  tpwm_prescaler u_pre (
    .clk(clk),
    .reset(reset),
    .cks(ctl0_r[TPWM_CKS_LSB +: 3]),
    .tick(pre_tick)
  );

  assign trig_if.sel = inedge_r[TPWM_ETS_LSB +: 2];
  assign evt_if.sel = inedge_r[TPWM_EES_LSB +: 2];

  // Bus answer: one wait cycle, then release
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata = rdata_r;
  assign wr_hit = avs_write & ack_r;

  // Handshake and read data capture
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      if (avs_read & ~ack_r) begin
        rdata_r <= rd_mux(avs_address);
      end
    end
  end

  // Register writes; capture and option offsets left unmapped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl0_r <= TPWM_RST_BYTE;
      ctl1_r <= TPWM_RST_BYTE;
      outpin_r <= TPWM_RST_BYTE;
      inedge_r <= TPWM_RST_BYTE;
      for (int i = 0; i < 4; i++) begin
        ccr_r[i] <= TPWM_RST_CCR;
      end
    end else if (wr_hit & avs_byteenable[0]) begin
      if (avs_address == TPWM_OFS_CTL0) begin
        ctl0_r <= avs_writedata[7:0];
      end else if (avs_address == TPWM_OFS_CTL1) begin
        // Soft trigger bit is not stored; it reads zero
        ctl1_r <= avs_writedata[7:0] & ~(8'h01 << TPWM_EST_BIT);
      end else if (avs_address == TPWM_OFS_OUTPIN) begin
        outpin_r <= avs_writedata[7:0];
      end else if (avs_address == TPWM_OFS_INEDGE) begin
        inedge_r <= avs_writedata[7:0];
      end else if (avs_address == TPWM_OFS_CCR0) begin
        ccr_r[0] <= upd16(ccr_r[0], avs_writedata, avs_byteenable);
      end else if (avs_address == TPWM_OFS_CCR1) begin
        ccr_r[1] <= upd16(ccr_r[1], avs_writedata, avs_byteenable);
      end else if (avs_address == TPWM_OFS_CCR2) begin
        ccr_r[2] <= upd16(ccr_r[2], avs_writedata, avs_byteenable);
      end else if (avs_address == TPWM_OFS_CCR3) begin
        ccr_r[3] <= upd16(ccr_r[3], avs_writedata, avs_byteenable);
      end
    end else if (wr_hit & avs_byteenable[1]) begin
      // High byte only reaches the 16-bit compare registers
      if (avs_address == TPWM_OFS_CCR0) begin
        ccr_r[0] <= upd16(ccr_r[0], avs_writedata, avs_byteenable);
      end else if (avs_address == TPWM_OFS_CCR1) begin
        ccr_r[1] <= upd16(ccr_r[1], avs_writedata, avs_byteenable);
      end else if (avs_address == TPWM_OFS_CCR2) begin
        ccr_r[2] <= upd16(ccr_r[2], avs_writedata, avs_byteenable);
      end else if (avs_address == TPWM_OFS_CCR3) begin
        ccr_r[3] <= upd16(ccr_r[3], avs_writedata, avs_byteenable);
      end
    end
  end

  // soft trigger pulse on a write of one
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      soft_trig_r <= 1'b0;
    end else begin
      soft_trig_r <= wr_hit & avs_byteenable[0] &
        (avs_address == TPWM_OFS_CTL1) & avs_writedata[TPWM_EST_BIT];
    end
  end

  // Core conditions
  always_comb begin
    // only mode 010 with run enable operates
    active = ctl0_r[TPWM_RUN_BIT] &
      (ctl1_r[TPWM_MD_LSB +: 3] == TPWM_MODE_TRIG_PWM);
    tick = ctl1_r[TPWM_EEE_BIT] ? evt_if.pulse : pre_tick;
    trig = trig_if.pulse | soft_trig_r;
    // Pin sources gathered so every pin index stays in range
    wave_src = {wave_r, tog_r};
    cnt_inc = cnt_r + 16'h0001;
    at_cycle = cnt_r == shadow_r[0];
    // trigger wins over a match in the same cycle
    wrap = (state_r == TPWM_RUN) & tick & at_cycle & ~trig;
    cnt_step = at_cycle ? 16'h0000 : cnt_inc;
    load = (state_r == TPWM_IDLE) & active;
  end

  // Counter and state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= TPWM_IDLE;
      cnt_r <= TPWM_CNT_IDLE;
    end else if (!active) begin
      // stop and wait for a new enable
      state_r <= TPWM_IDLE;
      cnt_r <= TPWM_CNT_IDLE;
    end else begin
      case (state_r)
        TPWM_IDLE: begin
          state_r <= TPWM_WAIT;
        end
        TPWM_WAIT: begin
          if (trig) begin
            state_r <= TPWM_RUN;
            cnt_r <= 16'h0000;
          end
        end
        default: begin
          if (trig) begin
            cnt_r <= 16'h0000;
          end else if (tick) begin
            cnt_r <= cnt_step;
          end
        end
      endcase
    end
  end

  // Compare shadows and transfer arming
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      armed_r <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        shadow_r[i] <= TPWM_RST_CCR;
      end
    end else begin
      // copy at enable and at armed cycle clear only
      if (load | (wrap & armed_r)) begin
        for (int i = 0; i < 4; i++) begin
          shadow_r[i] <= ccr_r[i];
        end
      end
      // phase one write arms; a new write wins
      if (wr_hit & (avs_address == TPWM_OFS_CCR1)) begin
        armed_r <= 1'b1;
      end else if (wrap | load) begin
        armed_r <= 1'b0;
      end
    end
  end

  // Waveforms and match pulses
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tog_r <= 1'b0;
      wave_r <= 3'h0;
      cyc_irq_r <= 1'b0;
      ph_irq_r <= 3'h0;
    end else begin
      cyc_irq_r <= 1'b0;
      ph_irq_r <= 3'h0;
      if (!active) begin
        tog_r <= 1'b0;
        wave_r <= 3'h0;
      end else if (trig & (state_r != TPWM_IDLE)) begin
        tog_r <= ~tog_r;
        wave_r <= 3'h7;
      end else if ((state_r == TPWM_RUN) & tick) begin
        if (wrap) begin
          tog_r <= ~tog_r;
          wave_r <= 3'h7;
          // cycle match pulse at the clear step
          cyc_irq_r <= 1'b1;
        end
        for (int b = 0; b < 3; b++) begin
          if (cnt_step == shadow_r[b + 1]) begin
            wave_r[b] <= 1'b0;
            ph_irq_r[b] <= 1'b1;
          end
        end
      end
    end
  end

  // pin drivers: enabled shows wave xor level, disabled shows level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pins_r <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (outpin_r[2 * k]) begin
          pins_r[k] <= wave_src[k] ^ outpin_r[2 * k + 1];
        end else begin
          pins_r[k] <= outpin_r[2 * k + 1];
        end
      end
    end
  end

  assign cycle_toggle_output = pins_r[0];
  assign pwm_phase_output = pins_r[3:1];
  assign cycle_match_irq = cyc_irq_r;
  assign phase_match_irq = ph_irq_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Trigger taken while the timer is armed or running
  sequence s_trig_live;
    trig && state_r != TPWM_IDLE && active;
  endsequence

  // Cycle match step with no competing trigger
  sequence s_cycle_match;
    wrap && active;
  endsequence

  a_mode_gate: assert property (state_r != TPWM_IDLE |-> $past(active))
    else $error("timer left idle outside the triggered PWM mode");
  a_trig_clear: assert property (s_trig_live |=> cnt_r == 16'h0000
    && state_r == TPWM_RUN)
    else $error("trigger did not clear and start the counter");
  a_trig_wave: assert property (s_trig_live |=> wave_r == 3'h7
    && tog_r != $past(tog_r))
    else $error("trigger did not force phases and invert toggle");
  a_cycle_clear: assert property (s_cycle_match |=> cnt_r == 16'h0000
    && cyc_irq_r && tog_r != $past(tog_r))
    else $error("cycle match did not clear, pulse and toggle");
  a_phase_match: assert property (ph_irq_r[0] |-> !wave_r[0]
    && cnt_r == $past(cnt_step))
    else $error("phase pulse without phase end at the match");
  a_shadow_hold: assert property (!$past(load) && !$past(wrap)
    |-> $stable(shadow_r[1]))
    else $error("phase shadow changed outside a counter clear");
  a_shadow_load: assert property (wrap && armed_r && active
    |=> shadow_r[0] == $past(ccr_r[0]))
    else $error("armed clear did not copy the cycle compare");
  a_tick_hold: assert property (state_r == TPWM_RUN && active && !tick
    && !trig |=> $stable(cnt_r))
    else $error("counter moved without a count tick");
  a_idle_stop: assert property (!active |=> state_r == TPWM_IDLE
    && cnt_r == TPWM_CNT_IDLE)
    else $error("run enable cleared but counter not idle");
  a_pin_level: assert property (!outpin_r[2] |=> pins_r[1]
    == $past(outpin_r[3]))
    else $error("disabled phase pin does not show its level bit");
endmodule
`default_nettype wire

// file: verif/tpwm_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// Far-side pulse source for the trigger and event pins
module tpwm_pin_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic trig_req,
  input wire logic evt_req,
  input wire logic [3:0] hold_len,
  output logic trigger_input,
  output logic event_count_input
);
  logic [3:0] trig_left_r; // Trigger high cycles left
  logic [3:0] evt_left_r; // Event high cycles left
  // Each request gives one high pulse; pins rest low between pulses
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trig_left_r <= 4'h0;
      evt_left_r <= 4'h0;
    end else begin
      if (trig_req) begin
        trig_left_r <= hold_len;
      end else if (trig_left_r != 4'h0) begin
        trig_left_r <= trig_left_r - 4'h1;
      end
      if (evt_req) begin
        evt_left_r <= hold_len;
      end else if (evt_left_r != 4'h0) begin
        evt_left_r <= evt_left_r - 4'h1;
      end
    end
  end
  // Levels held for hold_len clocks, never shorter than the sync needs
  assign trigger_input = (trig_left_r != 4'h0);
  assign event_count_input = (evt_left_r != 4'h0);
endmodule
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import tpwm_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic trigger_input;
  logic event_count_input;
  logic cycle_toggle_output;
  logic [2:0] pwm_phase_output;
  logic cycle_match_irq;
  logic [2:0] phase_match_irq;
  logic trig_req;
  logic evt_req;
  logic [3:0] hold_len;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  int n_mismatch = 0;
  int compares = 0;
  int seed = 32'h746e_12f0;
  int cyc_n = 0; // Timeout counter
  int irq0_n = 0; // Cycle irq pulses seen
  int ph_n[3] = '{0, 0, 0}; // Phase irq pulses seen
  int rise_n = 0; // Rising edges of phase one pin
  int gap = 0;
  int last_gap = 0; // Clocks between cycle irqs
  int hi = 0;
  int last_hi = 0; // Last high width of phase one pin
  int tcnt = 0;
  int last_tog = 0; // Last toggle half period
  logic prev_pwm = 1'b0;
  logic prev_tog = 1'b0;
  int s0, s1, s2, s3, s4;
  int per;
  logic t0;
  logic [31:0] rv;
  // Trigger edge codes under test; 2'h3 takes both edges
  logic [1:0] edge_tbl[4] = '{TPWM_EDGE_NONE, TPWM_EDGE_RISE,
    TPWM_EDGE_FALL, 2'h3};

  always #10 clk = ~clk;

  tpwm_timer tpwm_timer_inst (.clk(clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .trigger_input(trigger_input), .event_count_input(event_count_input),
    .cycle_toggle_output(cycle_toggle_output),
    .pwm_phase_output(pwm_phase_output), .cycle_match_irq(cycle_match_irq),
    .phase_match_irq(phase_match_irq));

  tpwm_pin_model tpwm_pin_model_inst (.clk(clk), .reset(reset),
    .trig_req(trig_req), .evt_req(evt_req), .hold_len(hold_len),
    .trigger_input(trigger_input), .event_count_input(event_count_input));

  // Prints the verdict and ends the run
  task automatic complete_run();
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One comparison of a result against its expectation
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a,
      input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // One idle edge so the next request never meets this release
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // Read notes its expectation; the read monitor compares it
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Snapshot of the event counters
  task automatic snap();
    s0 = irq0_n;
    s1 = ph_n[0];
    s2 = ph_n[1];
    s3 = ph_n[2];
    s4 = rise_n;
  endtask

  // Pulse on the far-side trigger pin, length random
  task automatic pin_trig();
    hold_len <= 4'(($unsigned($random(seed)) % 8) + 2);
    trig_req <= 1'b1;
    @(posedge clk);
    trig_req <= 1'b0;
  endtask

  // Waits a bounded time for a cycle clear pulse
  task automatic wait_clr();
    int k;
    k = 0;
    while (cycle_match_irq !== 1'b1 && k < 500) begin
      @(posedge clk);
      k++;
    end
    if (k == 500) chk(32'h0000_0000, 32'h0000_0001);
  endtask

  // Read monitor: takes the oldest note at the accepting rising edge
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        chk(avs_readdata, 32'hDEAD_BEEF);
      end else begin
        chk(avs_readdata, exp_q.pop_front());
      end
    end
  end

  // Pin monitor: counts mid-cycle, so snapshots never race it
  always @(negedge clk) begin
    cyc_n++;
    gap++;
    tcnt++;
    if (cycle_match_irq === 1'b1) begin
      irq0_n++;
      last_gap = gap;
      gap = 0;
    end
    for (int b = 0; b < 3; b++) begin
      if (phase_match_irq[b] === 1'b1) ph_n[b]++;
    end
    if (pwm_phase_output[0] === 1'b1) begin
      hi++;
      if (prev_pwm !== 1'b1) rise_n++;
    end else begin
      if (hi != 0) last_hi = hi;
      hi = 0;
    end
    if (cycle_toggle_output !== prev_tog) begin
      last_tog = tcnt;
      tcnt = 0;
    end
    prev_pwm = pwm_phase_output[0];
    prev_tog = cycle_toggle_output;
    if (cyc_n == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    trig_req = 1'b0;
    evt_req = 1'b0;
    hold_len = 4'h4;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // Idle values, read-only counter and an unmapped place
    rd(TPWM_OFS_CTL0, 32'h0000_0000);
    rd(TPWM_OFS_CNT, 32'h0000_FFFF);
    wr(TPWM_OFS_CNT, 32'h0000_1234);
    rd(TPWM_OFS_CNT, 32'h0000_FFFF);
    rd(6'h24, 32'h0000_0000);
    rv = $random(seed);
    wr(TPWM_OFS_CCR2, rv);
    rd(TPWM_OFS_CCR2, {16'h0000, rv[15:0]});
    // Disabled pins show their level bits
    wr(TPWM_OFS_OUTPIN, 32'h0000_00AA);
    cyc(3);
    chk({28'h0, cycle_toggle_output, pwm_phase_output}, 32'hF);
    wr(TPWM_OFS_OUTPIN, 32'h0000_0000);
    cyc(3);
    chk({28'h0, cycle_toggle_output, pwm_phase_output}, 32'h0);
    // A different mode code keeps the timer idle
    wr(TPWM_OFS_CTL1, 32'h0000_0001);
    wr(TPWM_OFS_CTL0, 32'h0000_0080);
    wr(TPWM_OFS_CTL1, 32'h0000_0041);
    cyc(8);
    rd(TPWM_OFS_CNT, 32'h0000_FFFF);
    wr(TPWM_OFS_CTL0, 32'h0000_0000);
    // Cycle 3, phase one 1, phase two 2, phase three parked
    wr(TPWM_OFS_CCR0, 32'h0000_0003);
    wr(TPWM_OFS_CCR2, 32'h0000_0002);
    wr(TPWM_OFS_CCR3, 32'h0000_FFFF);
    wr(TPWM_OFS_CCR1, 32'h0000_0001);
    wr(TPWM_OFS_OUTPIN, 32'h0000_0055);
    wr(TPWM_OFS_INEDGE, {30'h0, TPWM_EDGE_RISE});
    wr(TPWM_OFS_CTL1, {29'h0, TPWM_MODE_TRIG_PWM});
    for (int p = 0; p < 3; p += 2) begin
      per = 4 << p;
      // Prescale goes in with run enable
      wr(TPWM_OFS_CTL0, 32'h0000_0080 | p);
      rd(TPWM_OFS_CNT, 32'h0000_FFFF);
      wr(TPWM_OFS_CTL1, 32'h0000_0042);
      cyc(3 * per);
      snap();
      cyc(8 * per);
      chk(irq0_n - s0, 8);
      chk(ph_n[0] - s1, 8);
      chk(ph_n[1] - s2, 8);
      chk(ph_n[2] - s3, 0);
      chk(last_gap, per);
      chk(last_hi, 1 << p);
      chk(last_tog, per);
      wr(TPWM_OFS_CTL0, 32'h0000_0000);
      cyc(4);
      snap();
      rd(TPWM_OFS_CNT, 32'h0000_FFFF);
      cyc(20);
      chk(irq0_n - s0, 0);
    end
    // New cycle waits for the phase-one write
    wr(TPWM_OFS_CTL0, 32'h0000_0080);
    wr(TPWM_OFS_CTL1, 32'h0000_0042);
    cyc(20);
    wr(TPWM_OFS_CCR0, 32'h0000_0007);
    cyc(30);
    chk(last_gap, 4);
    wr(TPWM_OFS_CCR1, 32'h0000_0001);
    cyc(30);
    chk(last_gap, 8);
    // Long cycle, then pin retriggers under each edge code
    wr(TPWM_OFS_CCR0, 32'h0000_0080);
    wr(TPWM_OFS_CCR1, 32'h0000_0001);
    cyc(20);
    for (int e = 0; e < 4; e++) begin
      wait_clr();
      cyc(20);
      wr(TPWM_OFS_INEDGE, {30'h0, edge_tbl[e]});
      snap();
      t0 = cycle_toggle_output;
      pin_trig();
      cyc(24);
      chk(rise_n - s4, (e == 0) ? 0 : ((e == 3) ? 2 : 1));
      chk({31'h0, cycle_toggle_output ^ t0}, (e % 3 != 0) ? 1 : 0);
    end
    // Event edges as count clock, cycle of one
    wr(TPWM_OFS_CTL0, 32'h0000_0000);
    wr(TPWM_OFS_OUTPIN, 32'h0000_0054);
    wr(TPWM_OFS_CCR0, 32'h0000_0001);
    wr(TPWM_OFS_CCR1, 32'h0000_0001);
    wr(TPWM_OFS_INEDGE, {28'h0, TPWM_EDGE_RISE, TPWM_EDGE_NONE});
    wr(TPWM_OFS_CTL1, 32'h0000_0022);
    wr(TPWM_OFS_CTL0, 32'h0000_0080);
    wr(TPWM_OFS_CTL1, 32'h0000_0062);
    cyc(30);
    snap();
    repeat (8) begin
      hold_len <= 4'(($unsigned($random(seed)) % 8) + 2);
      evt_req <= 1'b1;
      @(posedge clk);
      evt_req <= 1'b0;
      cyc(24);
    end
    chk(irq0_n - s0, 4);
    complete_run();
  end
endmodule
`default_nettype wire
